// ==== design/gpc_pkg.sv ====
package gpc_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 22;
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;

    typedef logic [7:0] gpc_cfg_t;

    // ----------------------------------------------------------------
    // register indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_FAN_IR_KEYBOARD_PIN_DATA = 8'h4d;
    localparam logic [7:0] IDX_FLOPPY_WAKE_PIN_DATA     = 8'h4e;
    localparam logic [7:0] IDX_SECOND_SERIAL_PIN_DATA   = 8'h4f;
    localparam logic [7:0] IDX_INDICATOR_PIN_DATA       = 8'h50;
    localparam logic [7:0] IDX_PIN_CONFIGURATION_BASE   = 8'h60;

    // ----------------------------------------------------------------
    // pin numbering of the data registers
    // ----------------------------------------------------------------
    localparam int FIK_BASE    = 0;
    localparam int FLOPPY_BASE = 8;
    localparam int SERIAL_BASE = 12;
    localparam int IND_BASE    = 20;

    // ----------------------------------------------------------------
    // configuration fields and reset values
    // ----------------------------------------------------------------
    localparam int CFG_DIR    = 0;
    localparam int CFG_POL    = 1;
    localparam int CFG_ALT_LO = 2;
    localparam int CFG_ALT_HI = 3;
    localparam int CFG_OD     = 7;

    localparam logic [1:0] ALT_GPIO = 2'h0;
    localparam logic [1:0] ALT_EITHER_EDGE_INTERRUPT = 2'h2;

    localparam gpc_cfg_t CFG_RESET  = 8'h01;
    localparam logic     DATA_RESET = 1'b0;

endpackage

// ==== design/gpc_pin_cell.sv ====
module gpc_pin_cell
    import gpc_pkg::*;
#(
    parameter bit IS_JOY  = 1'b0,
    parameter bit IS_DEVICE_DISABLE_REG_CONTROL = 1'b0,
    parameter bit IS_SMI  = 1'b0,
    parameter bit IS_EITHER_EDGE_INTERRUPT = 1'b0
) (
    input  wire logic     clk,
    input  wire logic     rst,
    input  wire gpc_cfg_t cfg,
    input  wire logic     data,
    input  wire logic     pin,
    input  wire logic     alt_out,
    output logic          pad_o,
    output logic          pad_oe,
    output logic          rd_val,
    output logic          alt_in,
    output logic          is_out,
    output logic          alt_on
);

    // ----------------------------------------------------------------
    // function decode
    // ----------------------------------------------------------------
    logic [1:0] alt_sel;
    logic       either_edge_interrupt;
    logic       joy;
    logic       device_disable_reg_control;
    logic       pol_on;
    logic       dir_out;
    logic       src;
    logic       val;
    logic       od;

    assign alt_sel = cfg[CFG_ALT_HI:CFG_ALT_LO];
    assign alt_on  = alt_sel != ALT_GPIO;
    assign either_edge_interrupt    = IS_EITHER_EDGE_INTERRUPT && alt_sel == ALT_EITHER_EDGE_INTERRUPT;
    assign joy     = IS_JOY && alt_on;
    assign device_disable_reg_control    = IS_DEVICE_DISABLE_REG_CONTROL && alt_on;

    // ----------------------------------------------------------------
    // pin drive
    // ----------------------------------------------------------------
    assign pol_on  = cfg[CFG_POL] && !(joy || device_disable_reg_control || either_edge_interrupt);
    assign dir_out = joy || (!cfg[CFG_DIR] && !either_edge_interrupt);
    assign src     = alt_on ? alt_out : data;
    assign val     = src ^ pol_on;
    // driver type counts only for outputs, and for alternates only on the smi pin
    assign od      = joy || (dir_out && cfg[CFG_OD] && (!alt_on || IS_SMI));
    assign pad_o   = od ? 1'b0 : val;
    assign pad_oe  = dir_out && (!od || !val);

    // ----------------------------------------------------------------
    // pin sense
    // ----------------------------------------------------------------
    // edge mode still inverts the data bit, only the pin function ignores it
    assign rd_val  = pin ^ cfg[CFG_POL];
    assign alt_in  = pin ^ pol_on;
    // edge mode turns the pin into an input whatever the direction bit says
    assign is_out  = !cfg[CFG_DIR] && !either_edge_interrupt;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_input_no_drive: assert property (
        @(posedge clk) disable iff (rst)
        (cfg[CFG_DIR] && !joy) |-> !pad_oe)
        else $error("input pin is driven");

    a_od_no_high: assert property (
        @(posedge clk) disable iff (rst)
        od |-> !(pad_oe && pad_o))
        else $error("open-drain pin driven high");

    a_gpio_push_pull: assert property (
        @(posedge clk) disable iff (rst)
        (!alt_on && !cfg[CFG_DIR] && !cfg[CFG_OD])
            |-> (pad_oe && pad_o == (data ^ cfg[CFG_POL])))
        else $error("push-pull output value wrong");

    a_joy_open_drain: assert property (
        @(posedge clk) disable iff (rst)
        joy |-> (!pad_o && pad_oe == !alt_out))
        else $error("joystick pin not plain open-drain");

endmodule

// ==== design/gpc_pin_control.sv ====
// Overview of operation
// - every pin owns an 8-bit configuration register that steers its behaviour.
// - configuration bit 0 is direction, 0 making an output and 1 an input.
// - configuration bit 1 is polarity, 1 inverting both inputs and outputs.
// - an inverted input reads the inverted pin, an inverted output drives the inverted bit.
// - configuration bit 7 picks an open-drain or a push-pull driver.
// - the driver type matters only while the pin is an output.
// - the driver type covers the plain pin and the low-active interrupt alternate.
// - polarity also inverts alternate functions on every pin not excepted.
// - polarity skips the disable control, the joystick axes and either-edge mode.
// - a joystick axis alternate is always an open-drain, non-inverted output.
// - the four data registers sit at indices 4d, 4e, 4f and 50 of the block.
// - an input reads the pin level at read time and ignores writes to its bit.
// - an output reads back the last write, which also drives the pin unless an alternate is selected.
module gpc_pin_control
    import gpc_pkg::*;
#(
    parameter logic [NUM_PINS-1:0] JOY_MASK  = 22'h000000,
    parameter logic [NUM_PINS-1:0] DEVICE_DISABLE_REG_CONTROL_MASK = 22'h000800,
    parameter logic [NUM_PINS-1:0] SMI_MASK  = 22'h000000,
    parameter logic [NUM_PINS-1:0] EITHER_EDGE_INTERRUPT_MASK = 22'h300a00
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [ADDR_W-1:0]   PADDR,
    input  wire logic [DATA_W-1:0]   PWDATA,
    output logic      [DATA_W-1:0]   PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic [NUM_PINS-1:0] PAD_IN,
    output logic      [NUM_PINS-1:0] PAD_OUT,
    output logic      [NUM_PINS-1:0] PAD_OE,
    input  wire logic [NUM_PINS-1:0] ALT_OUT,
    output logic      [NUM_PINS-1:0] ALT_IN,
    output logic      [NUM_PINS-1:0] ALT_ACTIVE
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    logic [7:0] addr_idx;
    logic [7:0] cfg_off;
    logic       addr_ok;
    logic       hit_fik;
    logic       hit_floppy;
    logic       hit_serial;
    logic       hit_ind;
    logic       hit_cfg;
    logic       mapped;
    logic       setup;
    logic       wr_acc;

    assign addr_idx   = PADDR[9:2];
    assign addr_ok    = PADDR[1:0] == 2'h0 && PADDR[ADDR_W-1:10] == '0;
    assign hit_fik    = addr_ok && addr_idx == IDX_FAN_IR_KEYBOARD_PIN_DATA;
    assign hit_floppy = addr_ok && addr_idx == IDX_FLOPPY_WAKE_PIN_DATA;
    assign hit_serial = addr_ok && addr_idx == IDX_SECOND_SERIAL_PIN_DATA;
    assign hit_ind    = addr_ok && addr_idx == IDX_INDICATOR_PIN_DATA;
    assign cfg_off    = addr_idx - IDX_PIN_CONFIGURATION_BASE;
    assign hit_cfg    = addr_ok && addr_idx >= IDX_PIN_CONFIGURATION_BASE
                        && cfg_off < 8'(NUM_PINS);
    assign mapped     = hit_fik || hit_floppy || hit_serial || hit_ind || hit_cfg;
    assign setup      = PSEL && !PENABLE;
    assign wr_acc     = PSEL && PENABLE && PWRITE;

    // zero wait states: every access phase completes at once
    assign PREADY     = PSEL && PENABLE;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] pin_lvl;
    logic [NUM_PINS-1:0] agree;
    logic [NUM_PINS-1:0] next_pin_lvl;

    // a level only counts once two stages agree, which drops single-cycle glitches
    assign agree        = ~(sync2 ^ sync3);
    assign next_pin_lvl = (pin_lvl & ~agree) | (sync3 & agree);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= PAD_IN;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            pin_lvl <= '0;
        end else begin
            pin_lvl <= next_pin_lvl;
        end
    end

    // ----------------------------------------------------------------
    // per-pin configuration and pin cells
    // ----------------------------------------------------------------
    gpc_cfg_t            cfg [NUM_PINS];
    logic [NUM_PINS-1:0] cfg_sel;
    logic [NUM_PINS-1:0] data;
    logic [NUM_PINS-1:0] pad_o;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] rd_val;
    logic [NUM_PINS-1:0] alt_in;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] alt_on;

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        assign cfg_sel[i] = wr_acc && hit_cfg && cfg_off == 8'(i);

        always_ff @(posedge CLK_SYS or posedge RST) begin
            if (RST) begin
                cfg[i] <= CFG_RESET;
            end else if (cfg_sel[i]) begin
                cfg[i] <= PWDATA[7:0];
            end
        end

        gpc_pin_cell #(
            .IS_JOY  (JOY_MASK[i]),
            .IS_DEVICE_DISABLE_REG_CONTROL (DEVICE_DISABLE_REG_CONTROL_MASK[i]),
            .IS_SMI  (SMI_MASK[i]),
            .IS_EITHER_EDGE_INTERRUPT (EITHER_EDGE_INTERRUPT_MASK[i])
        ) u_cell (
            .clk     (CLK_SYS),
            .rst     (RST),
            .cfg     (cfg[i]),
            .data    (data[i]),
            .pin     (pin_lvl[i]),
            .alt_out (ALT_OUT[i]),
            .pad_o   (pad_o[i]),
            .pad_oe  (pad_oe[i]),
            .rd_val  (rd_val[i]),
            .alt_in  (alt_in[i]),
            .is_out  (pin_out[i]),
            .alt_on  (alt_on[i])
        );
    end

    // ----------------------------------------------------------------
    // data bits
    // ----------------------------------------------------------------
    logic [NUM_PINS-1:0] wr_val;
    logic [NUM_PINS-1:0] wr_hit;
    logic [NUM_PINS-1:0] wr_take;
    logic [NUM_PINS-1:0] next_data;

    // reserved bits have no storage, so their writes fall away
    assign wr_val  = {PWDATA[1:0], PWDATA[7:0], PWDATA[3:0], PWDATA[7:0]};
    assign wr_hit  = {{2{hit_ind}}, {8{hit_serial}}, {4{hit_floppy}}, {8{hit_fik}}};
    assign wr_take = {NUM_PINS{wr_acc}} & wr_hit & pin_out;
    assign next_data = (data & ~wr_take) | (wr_val & wr_take);

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            data <= {NUM_PINS{DATA_RESET}};
        end else begin
            data <= next_data;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [NUM_PINS-1:0] img;
    logic [DATA_W-1:0]   next_rdata;
    gpc_cfg_t            cfg_rd;

    // inputs show the level sampled in the setup cycle of the read
    assign img = (pin_out & data) | (~pin_out & rd_val);

    always_comb begin
        cfg_rd = '0;
        for (int k = 0; k < NUM_PINS; k++) begin
            if (cfg_off == 8'(k)) begin
                cfg_rd = cfg[k];
            end
        end
    end

    assign next_rdata = hit_fik    ? {24'h0, img[FIK_BASE +: 8]}    :
                        hit_floppy ? {28'h0, img[FLOPPY_BASE +: 4]} :
                        hit_serial ? {24'h0, img[SERIAL_BASE +: 8]} :
                        hit_ind    ? {30'h0, img[IND_BASE +: 2]}    :
                        hit_cfg    ? {24'h0, cfg_rd}                :
                                     32'h0;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PRDATA  <= '0;
            PSLVERR <= 1'b0;
        end else if (setup) begin
            PRDATA  <= next_rdata;
            PSLVERR <= !mapped;
        end
    end

    // ----------------------------------------------------------------
    // pad and alternate outputs
    // ----------------------------------------------------------------
    // one register stage keeps the pads free of decode glitches
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            PAD_OUT    <= '0;
            PAD_OE     <= '0;
            ALT_IN     <= '0;
            ALT_ACTIVE <= '0;
        end else begin
            PAD_OUT    <= pad_o;
            PAD_OE     <= pad_oe;
            ALT_IN     <= alt_in;
            ALT_ACTIVE <= alt_on;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_input_bit_kept: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        ##1 ((data ^ $past(data)) & ~$past(pin_out)) == '0)
        else $error("write changed an input data bit");

    a_output_bit_write: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && hit_fik) |=>
            ((data[7:0] ^ $past(PWDATA[7:0])) & $past(pin_out[7:0])) == 8'h0)
        else $error("output data bit missed its write");

    a_read_output_last: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_serial) |=>
            ((PRDATA[7:0] ^ data[SERIAL_BASE +: 8]) & pin_out[SERIAL_BASE +: 8]) == 8'h0)
        else $error("output read is not the last write");

    a_read_input_pin: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_fik) |=>
            ((PRDATA[7:0] ^ $past(rd_val[7:0])) & ~$past(pin_out[7:0])) == 8'h0)
        else $error("input read is not the pin level");

    a_floppy_reserved: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_floppy) |=> PRDATA[31:4] == 28'h0)
        else $error("reserved floppy data bits not zero");

    a_ind_reserved: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_ind) |=> PRDATA[31:2] == 30'h0)
        else $error("reserved indicator data bits not zero");

    a_cfg_write_back: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && hit_cfg && cfg_off == 8'h0) |=> cfg[0] == $past(PWDATA[7:0]))
        else $error("pin configuration write lost");

    a_data_addr_map: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && PADDR == 12'h134) |=> !PSLVERR)
        else $error("first data register not mapped");

    a_pin_filter: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (sync2 == sync3) |=> pin_lvl == $past(sync3))
        else $error("agreed pin level not taken");

    a_pad_follows: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        ##1 PAD_OE == $past(pad_oe) && PAD_OUT == $past(pad_o))
        else $error("pad outputs lag wrong");

    a_unmapped_err: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && !mapped) |=> (PSLVERR && PRDATA == '0))
        else $error("unmapped access not refused");

    a_mapped_no_err: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && mapped) |=> !PSLVERR)
        else $error("mapped access flagged as error");

    a_unmapped_no_write: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && !mapped) |=> data == $past(data))
        else $error("unmapped write changed data");

    a_floppy_write: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && hit_floppy) |=>
            ((data[FLOPPY_BASE +: 4] ^ $past(PWDATA[3:0]))
                & $past(pin_out[FLOPPY_BASE +: 4])) == 4'h0)
        else $error("floppy output bit missed its write");

    a_serial_write: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && hit_serial) |=>
            ((data[SERIAL_BASE +: 8] ^ $past(PWDATA[7:0]))
                & $past(pin_out[SERIAL_BASE +: 8])) == 8'h0)
        else $error("serial output bit missed its write");

    a_ind_write: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && hit_ind) |=>
            ((data[IND_BASE +: 2] ^ $past(PWDATA[1:0]))
                & $past(pin_out[IND_BASE +: 2])) == 2'h0)
        else $error("indicator output bit missed its write");

    a_read_floppy_pin: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_floppy) |=>
            ((PRDATA[3:0] ^ $past(rd_val[FLOPPY_BASE +: 4]))
                & ~$past(pin_out[FLOPPY_BASE +: 4])) == 4'h0)
        else $error("floppy input read is not the pin");

    a_read_serial_pin: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_serial) |=>
            ((PRDATA[7:0] ^ $past(rd_val[SERIAL_BASE +: 8]))
                & ~$past(pin_out[SERIAL_BASE +: 8])) == 8'h0)
        else $error("serial input read is not the pin");

    a_read_ind_pin: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_ind) |=>
            ((PRDATA[1:0] ^ $past(rd_val[IND_BASE +: 2]))
                & ~$past(pin_out[IND_BASE +: 2])) == 2'h0)
        else $error("indicator input read is not the pin");

    a_read_fik_output: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_fik) |=>
            ((PRDATA[7:0] ^ data[FIK_BASE +: 8]) & pin_out[FIK_BASE +: 8]) == 8'h0)
        else $error("output read is not the stored bit");

    a_cfg_read_back: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (setup && hit_cfg && cfg_off == 8'h0) |=> PRDATA[7:0] == cfg[0])
        else $error("pin configuration read wrong");

    a_cfg_others_kept: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (wr_acc && hit_cfg && cfg_off != 8'h0) |=> cfg[0] == $past(cfg[0]))
        else $error("pin configuration hit by foreign write");

    a_filter_hold: assert property (
        @(posedge CLK_SYS) disable iff (RST)
        (sync2 != sync3) |=> pin_lvl == $past(pin_lvl))
        else $error("pin level taken before stages agree");

endmodule

// ==== test/gpc_pin_partner.sv ====
module gpc_pin_partner
    import gpc_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] pad_out,
    input  wire logic [NUM_PINS-1:0] pad_oe,
    input  wire logic [NUM_PINS-1:0] ext_en,
    input  wire logic [NUM_PINS-1:0] ext_val,
    output logic      [NUM_PINS-1:0] pad_lvl
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // board wiring
    // ----------------------------------------------------------------
    // pull-up on every pin, so a released open-drain line reads high
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pad_lvl[i] = pad_oe[i] ? pad_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// ==== test/gpc_pin_control_tb_top.sv ====
module gpc_pin_control_tb_top
    import gpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [11:0] A_FIK = {2'b00, IDX_FAN_IR_KEYBOARD_PIN_DATA, 2'b00};
    localparam logic [11:0] A_FLP = {2'b00, IDX_FLOPPY_WAKE_PIN_DATA, 2'b00};
    localparam logic [11:0] A_SER = {2'b00, IDX_SECOND_SERIAL_PIN_DATA, 2'b00};
    localparam logic [11:0] A_IND = {2'b00, IDX_INDICATOR_PIN_DATA, 2'b00};

    logic                clk_sys;
    logic                rst;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [DATA_W-1:0]   pwdata;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic [NUM_PINS-1:0] pad_lvl;
    logic [NUM_PINS-1:0] pad_out;
    logic [NUM_PINS-1:0] pad_oe;
    logic [NUM_PINS-1:0] alt_out;
    logic [NUM_PINS-1:0] alt_in;
    logic [NUM_PINS-1:0] alt_active;
    logic [NUM_PINS-1:0] ext_en;
    logic [NUM_PINS-1:0] ext_val;
    logic [31:0]         r;
    logic                e;
    logic [7:0]          cfg_tab [6] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h03, 8'h81};
    int                  err_count = 0;
    int                  comparisons = 0;

    // pin 6 stands in for a joystick axis, pin 7 for the interrupt output
    gpc_pin_control #(.JOY_MASK(22'h000040), .SMI_MASK(22'h000080)) uut (
        .CLK_SYS(clk_sys), .RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .PAD_IN(pad_lvl), .PAD_OUT(pad_out),
        .PAD_OE(pad_oe), .ALT_OUT(alt_out), .ALT_IN(alt_in), .ALT_ACTIVE(alt_active)
    );

    gpc_pin_partner board (
        .pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pad_lvl(pad_lvl)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer, held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rr;
        logic        ee;
        apb(1'b1, a, d, rr, ee);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rr;
        logic        ee;
        apb(1'b0, a, 32'h0, rr, ee);
        check("prdata", rr, exp);
    endtask

    // synchroniser plus registered pads need five edges
    task automatic settle();
        repeat (6) @(posedge clk_sys);
    endtask

    function automatic logic [11:0] ca(input int p);
        return 12'h180 + 12'(4 * p);
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        alt_out = '0;
        ext_en = '1;
        ext_val = 22'h2a5a5a;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle();
        rchk(A_FIK, 32'h5a);
        rchk(A_FLP, 32'h0a);
        rchk(A_SER, 32'ha5);
        rchk(A_IND, 32'h02);
        rchk(ca(21), 32'h01);
        apb(1'b0, 12'h100, 32'h0, r, e);
        check("slverr", 32'(e), 32'h1);
        check("unmapped", r, 32'h0);
        apb(1'b1, 12'h100, 32'hff, r, e);
        check("wr_slverr", 32'(e), 32'h1);
        wr(A_FIK, 32'hff);
        wr(A_SER, 32'hff);
        wr(A_IND, 32'hff);
        rchk(A_FIK, 32'h5a);
        rchk(A_SER, 32'ha5);
        rchk(A_IND, 32'h02);
        @(posedge clk_sys);
        ext_en <= ext_en & ~22'h0010ff;
        alt_out[12] <= 1'b1;
        // stored bit stayed 0 while the pin was an input
        wr(ca(0), 32'h00);
        settle();
        check("pad0", 32'({pad_oe[0], pad_out[0]}), 32'h2);
        rchk(ca(0), 32'h00);
        for (int p = 1; p < 6; p++) begin
            wr(ca(p), 32'(cfg_tab[p]));
        end
        wr(A_FIK, 32'h0f);
        settle();
        check("pad_out", 32'(pad_out[3:0]), 32'h1);
        check("pad_oe", 32'(pad_oe[5:0]), 32'h0b);
        rchk(A_FIK, 32'hef);
        wr(A_FIK, 32'h00);
        settle();
        check("pad_out", 32'(pad_out[3:0]), 32'h2);
        check("pad_oe", 32'(pad_oe[3:0]), 32'h7);
        check("od_level", 32'(pad_lvl[3:2]), 32'h2);
        rchk(A_FIK, 32'he0);
        rchk(ca(3), 32'h82);
        wr(ca(6), 32'h07);
        wr(ca(7), 32'h84);
        settle();
        check("joy_smi", 32'({pad_oe[7:6], pad_out[7:6]}), 32'hc);
        check("alt_on", 32'(alt_active[7:6]), 32'h3);
        @(posedge clk_sys);
        alt_out[7:6] <= 2'b11;
        settle();
        check("joy_smi", 32'({pad_oe[7:6], pad_out[7:6]}), 32'h0);
        wr(ca(12), 32'h04);
        wr(ca(13), 32'h07);
        settle();
        check("alt_pad", 32'({pad_oe[12], pad_out[12]}), 32'h3);
        check("alt_in", 32'(alt_in[13]), 32'h1);
        check("alt_on", 32'(alt_active[13:12]), 32'h3);
        wr(ca(12), 32'h06);
        settle();
        check("alt_pad", 32'({pad_oe[12], pad_out[12]}), 32'h2);
        // either-edge pin ignores direction and driver type, and its bit is an input
        wr(ca(9), 32'h8a);
        wr(A_FLP, 32'h02);
        settle();
        check("edge_oe", 32'(pad_oe[9]), 32'h0);
        rchk(A_FLP, 32'h08);
        wr(ca(11), 32'h0f);
        settle();
        check("device_disable_reg_control_in", 32'(alt_in[11]), 32'h1);
        finish_test();
    end
endmodule
